//--- design/sapll_ctrl.v
// System analog PLL control: boot load of doubler and feedback divider, APB registers,
// derived lock window, loss-of-lock alarm and optional GPIO status drive.
// Assumes boot loader, loop filter code and APB master all run on pclk.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "sapll_map.vh"

module sapll_ctrl
#(
    parameter SETTLE_CYC = `SAPLL_SETTLE_CYC,
    parameter QUAL_CYC   = `SAPLL_QUAL_CYC
)
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        boot_ready,
    input  wire        otp_en,
    input  wire        otp_valid,
    input  wire [10:0] otp_word,
    input  wire        eeprom_en,
    input  wire        eeprom_valid,
    input  wire [10:0] eeprom_word,
    input  wire [9:0]  vc_code,
    output wire        doubler_en,
    output wire [9:0]  fb_div,
    output wire        lock_lost,
    output wire        gpio_status,
    output wire        gpio_status_oe_n
);

////////////////////////////////////////////////////////////////////////////////
// State and registers

localparam [1:0] ST_BOOT = 2'b01;      // Waiting for the loader
localparam [1:0] ST_RUN  = 2'b10;      // Normal operation

reg  [1:0]  state;                     // One-hot boot state
reg         dbl;                       // Doubler select
reg  [9:0]  div;                       // Feedback divider
reg         gpio_route;                // Alarm drives GPIO
reg  [47:0] freq_m;                    // Reference numerator
reg  [15:0] freq_n;                    // Reference denominator
reg         lol_sticky;                // Latched loss of lock
reg         from_otp;                  // Boot took OTP
reg         from_eep;                  // Boot took EEPROM
reg  [15:0] settle_cnt;                // Post-change hold-off
reg  [15:0] qual_cnt;                  // In-window qualification
reg  [31:0] rdata;                     // Registered read data
reg         lol_q;                     // Registered alarm
reg  [31:0] next_rdata;                // Read mux
wire        setup_ph;                  // APB setup cycle
wire        access_ph;                 // APB access cycle
wire        mapped;                    // Address decodes
wire        div_ok;                    // Written divider legal
wire        wr_ctrl;                   // Accepted control write
wire        refused;                   // Write refused
wire        otp_ok;                    // OTP usable
wire        eep_ok;                    // EEPROM usable
wire [9:0]  half_win;                  // Window half-width
wire [9:0]  win_lo;                    // Window low edge
wire [9:0]  win_hi;                    // Window high edge
wire        in_win;                    // Code inside window
wire        cfg_change;                // Config just changed
wire        boot_load;                 // Boot load cycle

////////////////////////////////////////////////////////////////////////////////
// APB decode

assign setup_ph  = psel & ~penable;
assign access_ph = psel & penable;
// Fixed map shared by every variant
assign mapped    = (paddr == `SAPLL_CTRL_OFS) | (paddr == `SAPLL_STATUS_OFS) |
                   (paddr == `SAPLL_GPIO_OFS) | (paddr == `SAPLL_FREQ_M_LO_OFS) |
                   (paddr == `SAPLL_FREQ_M_HI_OFS) | (paddr == `SAPLL_FREQ_N_OFS) |
                   (paddr == `SAPLL_WINDOW_OFS);
// Only legal divider values are accepted
assign div_ok    = (pwdata[`SAPLL_CTRL_DIV_MSB:`SAPLL_CTRL_DIV_LSB] >= `SAPLL_DIV_MIN) &&
                   (pwdata[`SAPLL_CTRL_DIV_MSB:`SAPLL_CTRL_DIV_LSB] <= `SAPLL_DIV_MAX);
// Control writes are refused until the boot load has finished
assign wr_ctrl   = access_ph & pwrite & (paddr == `SAPLL_CTRL_OFS) & state[1] & div_ok;
assign refused   = pwrite & (paddr == `SAPLL_CTRL_OFS) & ~(state[1] & div_ok);
assign pready    = 1'b1;
assign pslverr   = access_ph & (~mapped | refused);
assign prdata    = rdata;

////////////////////////////////////////////////////////////////////////////////
// Boot source choice

assign otp_ok    = otp_en & otp_valid;
assign eep_ok    = eeprom_en & eeprom_valid;
assign boot_load = state[0] & boot_ready;

// Boot state machine
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_BOOT;
    end
    else
    begin
        case (state)
            ST_BOOT:
            begin
                if (boot_ready)
                begin
                    state <= ST_RUN;
                end
            end
            ST_RUN:
            begin
                state <= ST_RUN;
            end
            default:
            begin
                state <= ST_BOOT;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers

// Loaded at boot, then written by software
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        dbl        <= `SAPLL_DBL_RST;
        div        <= `SAPLL_DIV_RST;
        gpio_route <= 1'b0;
        freq_m     <= `SAPLL_FREQ_M_RST;
        freq_n     <= `SAPLL_FREQ_N_RST;
        from_otp   <= 1'b0;
        from_eep   <= 1'b0;
    end
    else
    begin
        if (boot_load)
        begin
            // OTP first, then EEPROM, else keep defaults
            if (otp_ok)
            begin
                dbl      <= otp_word[0];
                div      <= otp_word[10:1];
                from_otp <= 1'b1;
            end
            else if (eep_ok)
            begin
                dbl      <= eeprom_word[0];
                div      <= eeprom_word[10:1];
                from_eep <= 1'b1;
            end
        end
        else if (wr_ctrl)
        begin
            dbl <= pwdata[`SAPLL_CTRL_DBL_BIT];
            div <= pwdata[`SAPLL_CTRL_DIV_MSB:`SAPLL_CTRL_DIV_LSB];
        end
        if (access_ph & pwrite)
        begin
            // Other writable words
            case (paddr)
                `SAPLL_GPIO_OFS:      gpio_route     <= pwdata[0];
                `SAPLL_FREQ_M_LO_OFS: freq_m[31:0]   <= pwdata;
                `SAPLL_FREQ_M_HI_OFS: freq_m[47:32]  <= pwdata[15:0];
                `SAPLL_FREQ_N_OFS:    freq_n         <= pwdata[15:0];
                default:              gpio_route     <= gpio_route;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Lock detection

// Window widens with the divider; nothing is user-set
assign half_win   = `SAPLL_WIN_BASE + {4'h0, div[9:4]};
assign win_lo     = `SAPLL_VC_MID - half_win;
assign win_hi     = `SAPLL_VC_MID + half_win;
assign in_win     = (vc_code >= win_lo) && (vc_code <= win_hi);
assign cfg_change = boot_load | wr_ctrl;

// Settle and qualification counters
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        settle_cnt <= SETTLE_CYC[15:0];
        qual_cnt   <= QUAL_CYC[15:0];
        lol_q      <= 1'b1;
        lol_sticky <= 1'b0;
    end
    else
    begin
        if (cfg_change)
        begin
            settle_cnt <= SETTLE_CYC[15:0];
        end
        else if (settle_cnt != 16'h0000)
        begin
            settle_cnt <= settle_cnt - 16'h0001;
        end
        if (cfg_change | ~in_win)
        begin
            qual_cnt <= QUAL_CYC[15:0];
        end
        else if (qual_cnt != 16'h0000)
        begin
            qual_cnt <= qual_cnt - 16'h0001;
        end
        // Held lost while booting or settling
        lol_q <= state[0] | cfg_change | (settle_cnt != 16'h0000) |
                 (qual_cnt != 16'h0000) | ~in_win;
        // New alarm beats a same-cycle clear
        if (lol_q & state[1])
        begin
            lol_sticky <= 1'b1;
        end
        else if (access_ph & pwrite & (paddr == `SAPLL_STATUS_OFS) & pwdata[`SAPLL_ST_LOL_STICKY])
        begin
            lol_sticky <= 1'b0;
        end
    end
end

assign lock_lost        = lol_q;
assign gpio_status      = lol_q & gpio_route;
assign gpio_status_oe_n = ~gpio_route;
assign doubler_en       = dbl;
assign fb_div           = div;

////////////////////////////////////////////////////////////////////////////////
// Read path

// Read mux, captured in the setup cycle
always @*
begin
    next_rdata = 32'h0000_0000;
    case (paddr)
        `SAPLL_CTRL_OFS:
        begin
            next_rdata[`SAPLL_CTRL_DBL_BIT]                   = dbl;
            next_rdata[`SAPLL_CTRL_DIV_MSB:`SAPLL_CTRL_DIV_LSB] = div;
        end
        `SAPLL_STATUS_OFS:
        begin
            next_rdata[`SAPLL_ST_LOL]        = lol_q;
            next_rdata[`SAPLL_ST_LOL_STICKY] = lol_sticky;
            next_rdata[`SAPLL_ST_BOOT_DONE]  = state[1];
            next_rdata[`SAPLL_ST_FROM_OTP]   = from_otp;
            next_rdata[`SAPLL_ST_FROM_EEP]   = from_eep;
            next_rdata[`SAPLL_ST_SETTLING]   = (settle_cnt != 16'h0000);
        end
        `SAPLL_GPIO_OFS:      next_rdata[0]     = gpio_route;
        `SAPLL_FREQ_M_LO_OFS: next_rdata        = freq_m[31:0];
        `SAPLL_FREQ_M_HI_OFS: next_rdata[15:0]  = freq_m[47:32];
        `SAPLL_FREQ_N_OFS:    next_rdata[15:0]  = freq_n;
        `SAPLL_WINDOW_OFS:
        begin
            next_rdata[9:0]   = win_lo;
            next_rdata[25:16] = win_hi;
        end
        default:              next_rdata        = 32'h0000_0000;
    endcase
end

// Read data register
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rdata <= 32'h0000_0000;
    end
    else if (setup_ph & ~pwrite)
    begin
        rdata <= next_rdata;
    end
end

endmodule // sapll_ctrl

//--- common/sapll_map.vh
// Register map, field layout, reset values and timing counts for the system PLL control block.
// Assumes a 10 MHz register clock and word-aligned 32-bit APB accesses.
`ifndef SAPLL_MAP_VH
`define SAPLL_MAP_VH

// Byte offsets, the same on every family member
`define SAPLL_CTRL_OFS      8'h00
`define SAPLL_STATUS_OFS    8'h04
`define SAPLL_GPIO_OFS      8'h08
`define SAPLL_FREQ_M_LO_OFS 8'h0C
`define SAPLL_FREQ_M_HI_OFS 8'h10
`define SAPLL_FREQ_N_OFS    8'h14
`define SAPLL_WINDOW_OFS    8'h18

// Control word fields
`define SAPLL_CTRL_DBL_BIT  0
`define SAPLL_CTRL_DIV_LSB  8
`define SAPLL_CTRL_DIV_MSB  17

// Status word fields
`define SAPLL_ST_LOL        0
`define SAPLL_ST_LOL_STICKY 1
`define SAPLL_ST_BOOT_DONE  2
`define SAPLL_ST_FROM_OTP   3
`define SAPLL_ST_FROM_EEP   4
`define SAPLL_ST_SETTLING   5

// Feedback divider limits and reset values
`define SAPLL_DIV_MIN       10'h06C
`define SAPLL_DIV_MAX       10'h22C
`define SAPLL_DIV_RST       10'h118
`define SAPLL_DBL_RST       1'b0
`define SAPLL_FREQ_M_RST    48'h0000_0000_0000
`define SAPLL_FREQ_N_RST    16'h0001

// Lock window derivation
`define SAPLL_VC_MID        10'h200
`define SAPLL_WIN_BASE      10'h010

// Timing
`define SAPLL_CLK_NS        100
`define SAPLL_QUAL_NS       10000
`define SAPLL_SETTLE_NS     100000
`define SAPLL_QUAL_CYC      (`SAPLL_QUAL_NS / `SAPLL_CLK_NS)
`define SAPLL_SETTLE_CYC    (`SAPLL_SETTLE_NS / `SAPLL_CLK_NS)

`endif

//--- tb/sapll_properties.sv
// Checker on the ports of the system PLL control block.
// Assumes one pclk domain with async active-low presetn.
`timescale 1ns/10ps
module sapll_props
#(
    parameter QUAL_CYC = 100
)
(
    input wire        pclk, presetn, psel, penable, pwrite, pslverr, boot_ready,
    input wire        otp_en, otp_valid, eeprom_en, eeprom_valid,
    input wire        doubler_en, lock_lost, gpio_status, gpio_status_oe_n,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [10:0] otp_word, eeprom_word,
    input wire [9:0]  vc_code, fb_div
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg        booted; // Loader already seen
    reg [7:0]  qcnt;   // Consecutive in-window samples
    wire       wr_ctrl = psel && penable && pwrite && paddr == 8'h00;
    wire [9:0] half    = 10'h010 + fb_div[9:4];
    wire       in_win  = vc_code >= 10'h200 - half && vc_code <= 10'h200 + half;
    wire [10:0] boot_w = (otp_en && otp_valid) ? otp_word : (eeprom_en && eeprom_valid) ? eeprom_word : 11'h230;
    // Track boot and in-window run length
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            booted <= 1'b0;
            qcnt   <= 8'h00;
        end
        else
        begin
            booted <= booted | boot_ready;
            qcnt   <= !in_win ? 8'h00 : (qcnt == 8'hFF ? qcnt : qcnt + 8'h01);
        end
    a_unmapped_refused: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access not refused");
    a_range_refused: assert property (wr_ctrl && (pwdata[17:8] < 10'h06C || pwdata[17:8] > 10'h22C)
        |-> pslverr ##1 $stable(fb_div)) else $error("out of range divider taken");
    a_early_refused: assert property (wr_ctrl && !booted |-> pslverr) else $error("write before boot");
    a_write_applies: assert property (wr_ctrl && !pslverr |=> fb_div == $past(pwdata[17:8])
        && doubler_en == $past(pwdata[0])) else $error("control write lost");
    a_write_unlocks: assert property (wr_ctrl && !pslverr |=> lock_lost [*8]) else $error("no relock");
    a_out_window: assert property (!in_win |=> lock_lost) else $error("lock outside window");
    a_lock_qualified: assert property ($fell(lock_lost) |-> qcnt >= QUAL_CYC - 1)
        else $error("lock too early");
    a_boot_load: assert property (boot_ready && !booted |=> {fb_div, doubler_en} == $past(boot_w))
        else $error("boot load wrong");
    a_alarm_pin: assert property (gpio_status == (lock_lost && !gpio_status_oe_n)) else $error("pin wrong");
    cover property (wr_ctrl && !pslverr);
    cover property ($fell(lock_lost));
    cover property (boot_ready && !booted && !otp_en && eeprom_valid);
endmodule // sapll_props

bind sapll_ctrl sapll_props #(.QUAL_CYC(QUAL_CYC)) sapll_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .boot_ready(boot_ready), .otp_en(otp_en),
    .otp_valid(otp_valid), .eeprom_en(eeprom_en), .eeprom_valid(eeprom_valid), .doubler_en(doubler_en),
    .lock_lost(lock_lost), .gpio_status(gpio_status), .gpio_status_oe_n(gpio_status_oe_n), .paddr(paddr),
    .pwdata(pwdata), .otp_word(otp_word), .eeprom_word(eeprom_word), .vc_code(vc_code), .fb_div(fb_div));

//--- tb/sapll_boot_mem.sv
// Boot memory model: OTP and serial EEPROM words for the loader.
// Assumes src selects which source is usable; words go stale after the load.
`timescale 1ns/10ps
module sapll_boot_mem
(
    input  wire        pclk, presetn,
    input  wire [1:0]  src,
    input  wire [10:0] otp_val, eep_val,
    output reg         boot_ready,
    output wire        otp_en, otp_valid, eeprom_en, eeprom_valid,
    output reg  [10:0] otp_word, eeprom_word
);
    reg [3:0] cnt; // Load delay
    assign otp_en       = src[0];
    assign otp_valid    = 1'b1;
    assign eeprom_en    = 1'b1;
    assign eeprom_valid = src[1];
    // Present words, raise ready, then scramble the released lines
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cnt <= 4'h0; boot_ready <= 1'b0; otp_word <= otp_val; eeprom_word <= eep_val;
        end
        else if (!boot_ready)
        begin
            cnt <= cnt + 4'h1; boot_ready <= cnt == 4'hB;
        end
        else
        begin
            otp_word <= ~otp_word; eeprom_word <= ~eeprom_word;
        end
endmodule // sapll_boot_mem

//--- tb/test_sapll_ctrl.sv
// Self-checking bench for the system PLL control block.
// Assumes APB with zero wait states and the boot memory model.
`timescale 1ns/10ps
`define SAPLL_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_sapll_ctrl;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0;
    reg  [31:0] r32; // Random numerator low word
    reg  [9:0]  vc_code = 10'h000, dexp, h;
    reg  [1:0]  src = 2'h0;
    reg  [10:0] otp_val = 11'h0, eep_val = 11'h0, w;
    wire [31:0] prdata;
    wire        pready, pslverr, boot_ready, otp_en, otp_valid, eeprom_en, eeprom_valid;
    wire        doubler_en, lock_lost, gpio_status, gpio_status_oe_n;
    wire [10:0] otp_word, eeprom_word;
    wire [9:0]  fb_div;
    int         bad_count = 0, comparisons = 0, seed = 43845, n;
    logic [64:0] exp_q[$], e;
    logic [9:0] lim[4] = '{10'h06B, 10'h22C, 10'h22D, 10'h06C};
    sapll_ctrl #(.SETTLE_CYC(20), .QUAL_CYC(5)) sapll_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_ready(boot_ready), .otp_en(otp_en), .otp_valid(otp_valid), .otp_word(otp_word),
        .eeprom_en(eeprom_en), .eeprom_valid(eeprom_valid), .eeprom_word(eeprom_word), .vc_code(vc_code),
        .doubler_en(doubler_en), .fb_div(fb_div), .lock_lost(lock_lost), .gpio_status(gpio_status),
        .gpio_status_oe_n(gpio_status_oe_n));
    sapll_boot_mem sapll_boot_mem_i (.pclk(pclk), .presetn(presetn), .src(src), .otp_val(otp_val),
        .eep_val(eep_val), .boot_ready(boot_ready), .otp_en(otp_en), .otp_valid(otp_valid),
        .eeprom_en(eeprom_en), .eeprom_valid(eeprom_valid), .otp_word(otp_word), .eeprom_word(eeprom_word));
    always #50 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [9:0] rnd_div();
        return 10'h06C + 10'($unsigned($random(seed)) % 449);
    endfunction
    // One APB transfer; the expected answer is queued first
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, m, ex, input logic er);
        exp_q.push_back({m, er, ex & m});
        @(posedge pclk); psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin bad_count++; final_report; end
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wait_lock(input logic v);
        n = 0;
        while (lock_lost !== v && n < 400) begin @(posedge pclk); n++; end
        if (n >= 400) begin bad_count++; final_report; end
    endtask
    // Reset with a chosen boot source, then check what was loaded
    task automatic boot(input logic [1:0] s);
        @(posedge pclk); presetn <= 1'b0; src <= s;
        otp_val <= {rnd_div(), 1'b1}; eep_val <= {rnd_div(), 1'b0};
        repeat (8) @(posedge pclk); presetn <= 1'b1;
        xfer(1, 8'h00, 32'h0000_7001, 0, 0, 1);
        n = 0;
        while (boot_ready !== 1'b1 && n < 50) begin @(posedge pclk); n++; end
        if (n >= 50) begin bad_count++; final_report; end
        repeat (2) @(posedge pclk);
        w = s[0] ? otp_val : s[1] ? eep_val : 11'h230;
        dexp = w[10:1];
        `SAPLL_CHK("boot", w, {fb_div, doubler_en})
        // Settling bit is still up: the boot load restarted the hold-off
        xfer(0, 8'h04, 0, 32'h3C, {26'h0, 1'b1, s == 2'h2, s[0], 1'b1, 2'h0}, 0);
    endtask
    // Result watcher: pops the oldest note at each completed transfer
    always @(posedge pclk)
        if (psel && penable && pready && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            `SAPLL_CHK("pslverr", e[32], pslverr)
            `SAPLL_CHK("prdata", e[31:0], prdata & e[64:33])
        end
    initial begin repeat (100000) @(posedge pclk); bad_count++; final_report; end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int s = 0; s < 4; s++) boot(2'(s));
        xfer(0, 8'h14, 0, 32'hFFFF, 32'h1, 0);
        xfer(1, 8'h10, 32'hFFFF_FFFF, 0, 0, 0);
        xfer(0, 8'h10, 0, 32'hFFFF, 32'hFFFF, 0);
        r32 = $random(seed);
        xfer(1, 8'h0C, r32, 0, 0, 0);
        xfer(0, 8'h0C, 0, 32'hFFFF_FFFF, r32, 0);
        foreach (lim[i])
        begin
            xfer(1, 8'h00, {14'h0, lim[i], 8'h00}, 0, 0, lim[i] < 10'h06C || lim[i] > 10'h22C);
            if (lim[i] >= 10'h06C && lim[i] <= 10'h22C) dexp = lim[i];
            @(posedge pclk);
            `SAPLL_CHK("fb_div", dexp, fb_div)
        end
        repeat (4)
        begin
            dexp = rnd_div();
            w = {dexp, 1'($random(seed))};
            xfer(1, 8'h00, {14'h0, dexp, 7'h0, w[0]}, 0, 0, 0);
            xfer(0, 8'h00, 0, 32'h3FF01, {14'h0, dexp, 7'h0, w[0]}, 0);
            `SAPLL_CHK("ctrl", w, {fb_div, doubler_en})
        end
        vc_code <= 10'h200;
        wait_lock(0);
        // Hold-off runs from the write; three edges already went on the read-back
        `SAPLL_CHK("settle", 1'b1, n + 3 > 20 && n + 3 <= 25)
        h = 10'h010 + dexp[9:4];
        xfer(0, 8'h18, 0, 32'h03FF_03FF, {6'h0, 10'h200 + h, 6'h0, 10'h200 - h}, 0);
        xfer(1, 8'h04, 32'h2, 0, 0, 0);
        xfer(0, 8'h04, 0, 32'h23, 32'h0, 0);
        xfer(1, 8'h08, 32'h1, 0, 0, 0);
        xfer(0, 8'h08, 0, 32'h1, 32'h1, 0);
        vc_code <= 10'h200 + h + 10'h001;
        wait_lock(1);
        `SAPLL_CHK("lol_fast", 1'b1, n <= 2)
        `SAPLL_CHK("pin", 2'b10, {gpio_status, gpio_status_oe_n})
        xfer(0, 8'h04, 0, 32'h3, 32'h3, 0);
        xfer(0, 8'h1C, 0, 32'hFFFF_FFFF, 0, 1);
        xfer(1, 8'hFC, 32'hFFFF_FFFF, 0, 0, 1);
        repeat (2) @(posedge pclk);
        final_report;
    end
endmodule // test_sapll_ctrl
